// file: rtl/hmfc_fifo.sv
// Module: first-word-fall-through FIFO with registered head data
`timescale 1ns/1ps
module hmfc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32,
    localparam int AW   = $clog2(DEPTH),
    localparam int CW   = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [CW-1:0]    count
);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];     // Word storage
    logic [AW-1:0]    wr_q, wr_d;      // Write pointer
    logic [AW-1:0]    rd_q, rd_d;      // Read pointer
    logic [CW-1:0]    cnt_q, cnt_d;    // Occupancy
    logic [WIDTH-1:0] head_q, head_d;  // Registered head word
    logic             push, pop;       // Accepted transfers

    // Full refuses writes; pointers wrap, so DEPTH must be a power of two
    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = head_q;
    assign count     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ------------------------------------------------------------
    // Next pointers and head
    // ------------------------------------------------------------
    always_comb begin
        wr_d   = push ? wr_q + AW'(1) : wr_q;
        rd_d   = pop ? rd_q + AW'(1) : rd_q;
        cnt_d  = cnt_q + CW'(push) - CW'(pop);
        // Bypass when the incoming word becomes the new head
        if (push && (wr_q == rd_d)) begin
            head_d = in_data;
        end else begin
            head_d = mem[rd_d];
        end
    end

    // Memory write port, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointer and head registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q   <= '0;
            rd_q   <= '0;
            cnt_q  <= '0;
            head_q <= '0;
        end else begin
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            cnt_q  <= cnt_d;
            head_q <= head_d;
        end
    end

endmodule

// file: rtl/hmfc_regs.sv
// Module: host MAC transmit/receive FIFO control and status registers
//
// Contract
// R1: First frame byte shifted by 0-31 pad bytes.
// R2: Host changes low pad bits only when idle.
// R3: Upper pad bits apply from next DWORD read.
// R4: Status flush write pulses flush, self-clears.
// R5: Data flush write pulses flush, self-clears.
// R6: Full status FIFO suspends sending unless overrun_ok.
// R7: Status-full interrupt independent of overrun_ok.
// R8: Transmitter enable sends pending FIFO data.
// R9: Enable clears itself after stop and halt.
// R10: Stop finishes frame, halts, then clears itself.
// R11: Writes to stop ignored while stop high.
// R12: Skip pops to next frame, high until done.
// R13: Host issues no data reads during skip.
// R14: Status FIFO DWORD count read back, eight bits.
// R15: Data level in bytes, whole DWORDs counted.
// R16: Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
module hmfc_regs
    import hmfc_pkg::*;
#(
    parameter int RX_DEPTH = 32,
    localparam int CW      = $clog2(RX_DEPTH + 1)
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire hmfc_bus_req_t bus_req,
    output logic        [31:0] bus_rdata,
    output logic               bus_rvalid,
    input  wire logic          rx_in_valid,
    output logic               rx_in_ready,
    input  wire hmfc_rx_word_t rx_in_word,
    input  wire logic          rxd_rd_req,
    output logic        [31:0] rxd_rd_data,
    output logic               rxd_rd_valid,
    input  wire logic   [7:0]  rx_status_level,
    input  wire logic          tx_busy,
    input  wire logic          tx_status_full,
    output logic               tx_send_enable,
    output logic               tx_status_flush,
    output logic               tx_data_flush,
    output logic               tx_status_full_irq
);

    // ------------------------------------------------------------
    // Read-side states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SOF  = 3'b001,  // Frame start, pad DWORDs pending
        ST_BODY = 3'b010,  // Inside a frame
        ST_TAIL = 3'b100   // Carry bytes still to deliver
    } hmfc_rd_state_t;

    // Shared address decode
    function automatic logic reg_hit(input hmfc_bus_req_t r, input logic [7:0] off);
        reg_hit = r.cs && (r.addr == off);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hmfc_tx_cfg_t   cfg_q, cfg_d;          // Transmit control bits
    logic           sfl_q, sfl_d;          // Status flush pulse
    logic           dfl_q, dfl_d;          // Data flush pulse
    logic           irq_q, irq_d;          // Status full interrupt
    logic [4:0]     pad_bytes_q, pad_bytes_d;  // rx_start_pad_bytes
    logic           skip_q, skip_d;        // rx_skip_to_next_frame
    hmfc_rd_state_t st_q, st_d;            // Read-side state
    logic [2:0]     padc_q, padc_d;        // Pad DWORDs emitted
    logic [31:0]    carry_q, carry_d;      // Bytes pushed past a word
    logic [31:0]    rdd_q, rdd_d;          // Data read result
    logic           rdv_q, rdv_d;          // Data read valid
    logic [31:0]    brd_q, brd_d;          // Register read result
    logic           brv_q, brv_d;          // Register read valid
    logic           wr_txc, wr_rxc, wr_dpc;    // Write decodes
    logic           fifo_valid, fifo_pop;  // FIFO head handshake
    hmfc_rx_word_t  fifo_word;             // FIFO head word
    logic [CW-1:0]  fifo_cnt;              // FIFO occupancy, DWORDs
    logic [15:0]    rx_data_level_bytes;   // Occupancy in bytes
    logic [63:0]    wide;                  // Head word after byte shift

    assign wr_txc = reg_hit(bus_req, TX_CONF_OFF) && bus_req.we;
    assign wr_rxc = reg_hit(bus_req, RX_CONF_OFF) && bus_req.we;
    assign wr_dpc = reg_hit(bus_req, RX_DPC_OFF) && bus_req.we;

    // ------------------------------------------------------------
    // Receive data FIFO
    // ------------------------------------------------------------
    hmfc_fifo #(
        .WIDTH ($bits(hmfc_rx_word_t)),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .in_data   (rx_in_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word),
        .count     (fifo_cnt)
    );

    // Whole DWORDs only, so a ragged frame end already counts rounded up
    assign rx_data_level_bytes = 16'({fifo_cnt, 2'b00});  // see R15

    // ------------------------------------------------------------
    // Transmit control
    // ------------------------------------------------------------
    // Only new frames are gated; the transmitter finishes its current one
    assign tx_send_enable = cfg_q.tx_on && !cfg_q.stop      // see R8
                            && (cfg_q.overrun_ok || !tx_status_full);  // see R6
    assign tx_status_flush    = sfl_q;
    assign tx_data_flush      = dfl_q;
    assign tx_status_full_irq = irq_q;

    // Next transmit control values
    always_comb begin
        cfg_d = cfg_q;
        sfl_d = 1'b0;
        dfl_d = 1'b0;
        irq_d = tx_status_full;  // see R7
        if (wr_txc) begin
            sfl_d            = bus_req.wdata[TXS_FLUSH_BIT];  // see R4
            dfl_d            = bus_req.wdata[TXD_FLUSH_BIT];  // see R5
            cfg_d.overrun_ok = bus_req.wdata[OVR_OK_BIT];
            cfg_d.tx_on      = bus_req.wdata[TX_ON_BIT];
            // A pending stop cannot be cancelled or retriggered
            if (!cfg_q.stop) begin
                cfg_d.stop = bus_req.wdata[STOP_BIT];  // see R11
            end
        end
        // Halted after stop: both bits drop together
        if (cfg_q.stop && !tx_busy) begin
            cfg_d.stop  = 1'b0;  // see R10
            cfg_d.tx_on = 1'b0;  // see R9
        end
    end

    // Transmit control registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_q <= '{overrun_ok: OVR_OK_RST, tx_on: TX_ON_RST, stop: STOP_RST};
            sfl_q <= 1'b0;
            dfl_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            sfl_q <= sfl_d;
            dfl_q <= dfl_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Receive read path: padding, byte shift and skip
    // ------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        padc_d      = padc_q;
        carry_d     = carry_q;
        skip_d      = skip_q;
        rdd_d       = rdd_q;
        rdv_d       = 1'b0;
        fifo_pop    = 1'b0;
        pad_bytes_d = pad_bytes_q;
        // Low two bits give the byte shift inside a DWORD
        wide = {32'h0000_0000, fifo_word.data} << {pad_bytes_q[1:0], 3'b000};  // see R1
        if (wr_rxc) begin
            pad_bytes_d = bus_req.wdata[PAD_MSB:PAD_LSB];
        end
        if (skip_q) begin
            // Reads are refused while skipping
            if (st_q == ST_TAIL) begin  // see R13
                skip_d  = 1'b0;
                st_d    = ST_SOF;
                padc_d  = 3'h0;
                carry_d = 32'h0000_0000;
            end else if (fifo_valid) begin
                fifo_pop = 1'b1;  // see R12
                if (fifo_word.last) begin
                    skip_d  = 1'b0;
                    st_d    = ST_SOF;
                    padc_d  = 3'h0;
                    carry_d = 32'h0000_0000;
                end
            end
        end else if (rxd_rd_req) begin
            rdv_d = 1'b1;
            unique case (st_q)
                ST_SOF: begin
                    // Pad count is read live, so a change lands on the next read
                    if (padc_q < pad_bytes_q[4:2]) begin  // see R3
                        rdd_d  = 32'h0000_0000;
                        padc_d = padc_q + 3'h1;
                    end else if (fifo_valid) begin
                        fifo_pop = 1'b1;
                        rdd_d    = wide[31:0];
                        carry_d  = wide[63:32];
                        padc_d   = 3'h0;
                        st_d     = ST_BODY;
                        if (fifo_word.last) begin
                            st_d = (pad_bytes_q[1:0] != 2'h0) ? ST_TAIL : ST_SOF;
                        end
                    end else begin
                        rdd_d = 32'h0000_0000;
                    end
                end
                ST_BODY: begin
                    if (fifo_valid) begin
                        fifo_pop = 1'b1;
                        rdd_d    = wide[31:0] | carry_q;  // see R1
                        carry_d  = wide[63:32];
                        if (fifo_word.last) begin
                            st_d = (pad_bytes_q[1:0] != 2'h0) ? ST_TAIL : ST_SOF;
                        end
                    end else begin
                        // Underflow returns zero and keeps position
                        rdd_d = 32'h0000_0000;
                    end
                end
                ST_TAIL: begin
                    rdd_d   = carry_q;
                    carry_d = 32'h0000_0000;
                    st_d    = ST_SOF;
                end
            endcase
        end
        // A new skip request wins over completion in the same cycle
        if (wr_dpc && bus_req.wdata[SKIP_BIT]) begin
            skip_d = 1'b1;  // see R12
        end
    end

    // Read path registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q        <= ST_SOF;
            padc_q      <= 3'h0;
            carry_q     <= 32'h0000_0000;
            skip_q      <= SKIP_RST;
            rdd_q       <= 32'h0000_0000;
            rdv_q       <= 1'b0;
            pad_bytes_q <= PAD_RST;
        end else begin
            st_q        <= st_d;
            padc_q      <= padc_d;
            carry_q     <= carry_d;
            skip_q      <= skip_d;
            rdd_q       <= rdd_d;
            rdv_q       <= rdv_d;
            pad_bytes_q <= pad_bytes_d;
        end
    end

    assign rxd_rd_data  = rdd_q;
    assign rxd_rd_valid = rdv_q;

    // ------------------------------------------------------------
    // Register read mux; reserved and unmapped bits read zero
    // ------------------------------------------------------------
    always_comb begin
        brd_d = 32'h0000_0000;  // see R16
        brv_d = bus_req.cs && !bus_req.we;
        if (reg_hit(bus_req, RX_CONF_OFF)) begin
            brd_d[PAD_MSB:PAD_LSB] = pad_bytes_q;
        end else if (reg_hit(bus_req, TX_CONF_OFF)) begin
            // Flush bits are write-only and read zero
            brd_d[OVR_OK_BIT] = cfg_q.overrun_ok;
            brd_d[TX_ON_BIT]  = cfg_q.tx_on;
            brd_d[STOP_BIT]   = cfg_q.stop;
        end else if (reg_hit(bus_req, RX_DPC_OFF)) begin
            brd_d[SKIP_BIT] = skip_q;
        end else if (reg_hit(bus_req, RX_LVL_OFF)) begin
            brd_d[STS_LVL_LSB +: 8]   = rx_status_level;  // see R14
            brd_d[DATA_LVL_LSB +: 16] = rx_data_level_bytes;
        end
        if (!brv_d) begin
            brd_d = brd_q;
        end
    end

    // Register read outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            brd_q <= 32'h0000_0000;
            brv_q <= 1'b0;
        end else begin
            brd_q <= brd_d;
            brv_q <= brv_d;
        end
    end

    assign bus_rdata  = brd_q;
    assign bus_rvalid = brv_q;

    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_STS_FLUSH: assert property (wr_txc && bus_req.wdata[15] ##1 !(wr_txc && bus_req.wdata[15]) // see R4
                                    |-> tx_status_flush ##1 !tx_status_flush)
        else $error("status flush not a single pulse");
    AST_DATA_FLUSH: assert property (wr_txc && bus_req.wdata[14] ##1 !(wr_txc && bus_req.wdata[14]) // see R5
                                     |-> tx_data_flush ##1 !tx_data_flush)
        else $error("data flush not a single pulse");
    AST_SUSPEND: assert property (tx_status_full && !cfg_q.overrun_ok |-> !tx_send_enable) // see R6
        else $error("sending with full status FIFO");
    AST_IRQ: assert property (tx_status_full |=> tx_status_full_irq) // see R7
        else $error("status full interrupt missing");
    AST_SEND: assert property (cfg_q.tx_on && !cfg_q.stop && !tx_status_full |-> tx_send_enable) // see R8
        else $error("enabled transmitter not sending");
    AST_HALT: assert property (cfg_q.stop && !tx_busy |=> !cfg_q.stop && !cfg_q.tx_on) // see R9
        else $error("stop or enable not cleared after halt");
    AST_STOP_HOLD: assert property (cfg_q.stop && tx_busy |=> cfg_q.stop) // see R10
        else $error("stop dropped during frame");
    AST_STOP_IGN: assert property (cfg_q.stop && tx_busy && wr_txc && !bus_req.wdata[0] |=> cfg_q.stop) // see R11
        else $error("write to pending stop took effect");
    AST_SKIP_HOLD: assert property (skip_q && !(fifo_pop && fifo_word.last) && st_q != ST_TAIL |=> skip_q) // see R12
        else $error("skip ended before frame end");
    AST_PAD_ZERO: assert property (!skip_q && rxd_rd_req && st_q == ST_SOF && padc_q < pad_bytes_q[4:2]
                                   |=> rxd_rd_valid && rxd_rd_data == 32'h0000_0000) // see R1
        else $error("pad DWORD not zero");
    AST_LEVEL: assert property (brv_d && reg_hit(bus_req, RX_LVL_OFF)
                                |=> bus_rdata[31:24] == 8'h00 && bus_rdata[23:16] == $past(rx_status_level)) // see R14
        else $error("status level read wrong");
    AST_RSVD: assert property (brv_d && reg_hit(bus_req, RX_DPC_OFF) |=> bus_rdata[30:0] == 31'h0) // see R16
        else $error("reserved bits not zero");

    COV_SKIP: cover property (skip_q ##[1:40] !skip_q);
    COV_STOP: cover property (cfg_q.stop ##[1:40] !cfg_q.tx_on);
    COV_TAIL: cover property (rxd_rd_req && st_q == ST_TAIL);
    COV_FULL: cover property (!rx_in_ready);

endmodule

// file: shared/hmfc_pkg.sv
// Package: register map, field layout and carrier types of the host MAC FIFO control registers
package hmfc_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the host bus)
    // ------------------------------------------------------------
    localparam logic [7:0] RX_CONF_OFF   = 8'h6C;  // receive_config
    localparam logic [7:0] TX_CONF_OFF   = 8'h70;  // transmit_config
    localparam logic [7:0] RX_DPC_OFF    = 8'h78;  // receive_datapath_control
    localparam logic [7:0] RX_LVL_OFF    = 8'h7C;  // receive_fifo_levels

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PAD_LSB        = 8;   // rx_start_pad_bytes low bit
    localparam int PAD_MSB        = 12;  // rx_start_pad_bytes high bit
    localparam int TXS_FLUSH_BIT  = 15;  // tx_status_flush
    localparam int TXD_FLUSH_BIT  = 14;  // transmit data flush
    localparam int OVR_OK_BIT     = 2;   // tx_status_overrun_ok
    localparam int TX_ON_BIT      = 1;   // transmitter enable
    localparam int STOP_BIT       = 0;   // stop transmitter
    localparam int SKIP_BIT       = 31;  // rx_skip_to_next_frame
    localparam int STS_LVL_LSB    = 16;  // rx_status_level low bit
    localparam int DATA_LVL_LSB   = 0;   // rx_data_level_bytes low bit

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] PAD_RST     = 5'h00;
    localparam logic       OVR_OK_RST  = 1'b0;
    localparam logic       TX_ON_RST   = 1'b0;
    localparam logic       STOP_RST    = 1'b0;
    localparam logic       SKIP_RST    = 1'b0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cs;     // Access strobe, one cycle
        logic        we;     // 1 = write, 0 = read
        logic [7:0]  addr;   // Byte address
        logic [31:0] wdata;  // Write data
    } hmfc_bus_req_t;

    typedef struct packed {
        logic        last;   // Final DWORD of a frame
        logic [31:0] data;   // Payload, first byte in low lane
    } hmfc_rx_word_t;

    typedef struct packed {
        logic overrun_ok;    // Keep sending with full status FIFO
        logic tx_on;         // Transmitter enable
        logic stop;          // Stop request pending
    } hmfc_tx_cfg_t;

endpackage

// file: verif/hmfc_tx_model.sv
// Far-side transmitter model: sends queued frames and reports status FIFO full
`timescale 1ns/1ps
module hmfc_tx_model #(
    parameter int FRAME_LEN = 20  // Cycles per frame on the wire
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic send_enable,
    input  wire logic add_frame,
    input  wire logic full_cmd,
    output logic      tx_busy,
    output logic      tx_status_full
);
    int  pending;  // Frames waiting in the data FIFO
    int  left;     // Cycles left of the frame in flight
    logic start;   // A new frame begins this cycle
    // Status space is scripted by the bench, so full can be forced at will
    assign tx_status_full = full_cmd;
    assign start          = (left == 0) && send_enable && (pending > 0);
    assign tx_busy        = (left > 0);
    // A started frame always runs to its end, whatever the enable does
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending <= 0;
            left    <= 0;
        end else begin
            left    <= start ? FRAME_LEN : (left > 0 ? left - 1 : 0);
            pending <= pending + int'(add_frame) - int'(start);
        end
    end
endmodule

// file: verif/host_mac_fifo_control_regs_test.sv
// Self-checking bench for the FIFO control registers, byte-queue reference model
`timescale 1ns/1ps
module host_mac_fifo_control_regs_test;
    import hmfc_pkg::*;
    logic          clk, reset, bus_rvalid, rx_in_valid, rx_in_ready, rxd_rd_req, rxd_rd_valid;
    logic          tx_busy, tx_status_full, tx_send_enable, tx_status_flush, tx_data_flush;
    logic          tx_status_full_irq, add_frame, full_cmd;
    hmfc_bus_req_t bus_req;
    hmfc_rx_word_t rx_in_word;
    logic [31:0]   bus_rdata, rxd_rd_data;
    logic [7:0]    rx_status_level;
    int            n_mismatch, n_compared, cyc;

    hmfc_regs #(.RX_DEPTH(32)) i_dut (
        .clk(clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_word(rx_in_word),
        .rxd_rd_req(rxd_rd_req), .rxd_rd_data(rxd_rd_data), .rxd_rd_valid(rxd_rd_valid),
        .rx_status_level(rx_status_level), .tx_busy(tx_busy), .tx_status_full(tx_status_full),
        .tx_send_enable(tx_send_enable), .tx_status_flush(tx_status_flush),
        .tx_data_flush(tx_data_flush), .tx_status_full_irq(tx_status_full_irq));
    hmfc_tx_model #(.FRAME_LEN(20)) i_far (
        .clk(clk), .reset(reset), .send_enable(tx_send_enable), .add_frame(add_frame),
        .full_cmd(full_cmd), .tx_busy(tx_busy), .tx_status_full(tx_status_full));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One bus access; returns just after the taking edge, when effects are visible
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 bus_req = '{cs: 1'b1, we: we, addr: a, wdata: d};
        @(posedge clk);
        #1 bus_req.cs = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check({31'h0, bus_rvalid}, 32'h1);
        check(bus_rdata, exp);
    endtask
    task automatic push(input logic last, input logic [31:0] d);
        @(posedge clk);
        #1 rx_in_valid = 1'b1;
        rx_in_word = '{last: last, data: d};
        @(posedge clk);
        #1 rx_in_valid = 1'b0;
    endtask
    task automatic rxrd(input logic [31:0] exp);
        @(posedge clk);
        #1 rxd_rd_req = 1'b1;
        @(posedge clk);
        #1 rxd_rd_req = 1'b0;
        check({31'h0, rxd_rd_valid}, 32'h1);
        check(rxd_rd_data, exp);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0]  b[$];
        logic [31:0] w;
        int          pad, n, k;
        reset = 1'b1;
        bus_req = '0;
        rx_in_valid = 1'b0;
        rx_in_word = '0;
        rxd_rd_req = 1'b0;
        rx_status_level = 8'h00;
        add_frame = 1'b0;
        full_cmd = 1'b0;
        void'($urandom(2647));
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        rd(RX_CONF_OFF, 32'h0);
        rd(RX_DPC_OFF, 32'h0);
        rd(8'h74, 32'h0);
        // Flush pulses, reserved bits dropped
        acc(1'b1, TX_CONF_OFF, 32'hFFFF_C004);
        check({30'h0, tx_status_flush, tx_data_flush}, 32'h3);
        @(posedge clk) #1;
        check({30'h0, tx_status_flush, tx_data_flush}, 32'h0);
        rd(TX_CONF_OFF, 32'h4);
        // Full status FIFO with and without overrun allowed
        acc(1'b1, TX_CONF_OFF, 32'h6);
        full_cmd = 1'b1;
        repeat (2) @(posedge clk) #1;
        check({30'h0, tx_send_enable, tx_status_full_irq}, 32'h3);
        acc(1'b1, TX_CONF_OFF, 32'h2);
        check({30'h0, tx_send_enable, tx_status_full_irq}, 32'h1);
        full_cmd = 1'b0;
        // Stop in mid-frame: writes to stop ignored, both bits clear after halt
        add_frame = 1'b1;
        @(posedge clk) #1 add_frame = 1'b0;
        for (k = 0; k < 50 && tx_busy !== 1'b1; k++) @(posedge clk) #1;
        check({31'h0, tx_busy}, 32'h1);
        acc(1'b1, TX_CONF_OFF, 32'h3);
        check({31'h0, tx_send_enable}, 32'h0);
        acc(1'b1, TX_CONF_OFF, 32'h2);
        rd(TX_CONF_OFF, 32'h3);
        for (k = 0; k < 50 && tx_busy !== 1'b0; k++) @(posedge clk) #1;
        repeat (2) @(posedge clk);
        rd(TX_CONF_OFF, 32'h0);
        // Fill until refused, then skip the whole frame
        rx_status_level = 8'($urandom);
        for (k = 0; k < 32; k++) push(k == 31, $urandom);
        check({31'h0, rx_in_ready}, 32'h0);
        rd(RX_LVL_OFF, {8'h0, rx_status_level, 16'd128});
        acc(1'b1, RX_DPC_OFF, 32'h8000_0000);
        rd(RX_DPC_OFF, 32'h8000_0000);
        // No data reads until the skip flag drops
        for (k = 0; k < 60 && bus_rdata[31] !== 1'b0; k++) acc(1'b0, RX_DPC_OFF, 32'h0);
        check(bus_rdata, 32'h0);
        rd(RX_LVL_OFF, {8'h0, rx_status_level, 16'h0});
        // Random frames with random pad; pad changed only while idle
        repeat (6) begin
            pad = $urandom_range(31);
            n = $urandom_range(5, 1);
            rx_status_level = 8'($urandom);
            acc(1'b1, RX_CONF_OFF, 32'(pad) << 8);
            rd(RX_CONF_OFF, 32'(pad) << 8);
            b.delete();
            repeat (pad) b.push_back(8'h00);
            for (k = 0; k < n; k++) begin
                w = $urandom;
                push(k == n - 1, w);
                for (int j = 0; j < 4; j++) b.push_back(w[8*j +: 8]);
            end
            rd(RX_LVL_OFF, {8'h0, rx_status_level, 16'(4 * n)});
            while (b.size() % 4 != 0) b.push_back(8'h00);
            while (b.size() > 0) begin
                rxrd({b[3], b[2], b[1], b[0]});
                repeat (4) void'(b.pop_front());
            end
        end
        print_verdict();
    end
endmodule
